/* cmd_exec.v */
// Command ring executor: No Op, Enable Slot, abort and ring stop handling
// Functional notes
// R1: Snapshot slot state before executing each command, for undo on abort.
// R2: Abort before completion posted restores snapshot and reports aborted code.
// R3: Abort after normal completion just stops the ring, no aborted code.
// R4: Software times abort; resets controller if ring still runs after 5 s.
// R5: No Op changes no controller or device state.
// R6: No Op event: descriptor address, success, other fields zero, event cycle.
// R7: Software builds No Op with type code only, cycle bit, doorbell.
// R8: Software may use No Op descriptors purely as padding.
// R9: Enable Slot picks a free slot, enables it, returns its id, success.
// R10: No free slot returns id zero with no-slots-available code.
// R11: Enable Slot event carries descriptor address, zero fields, event cycle bit.
// R12: Any free slot selection policy is acceptable.
// R13: Software fills slot type from protocol capability, zeros rest, rings doorbell.
// R14: Software stores device context pointer before using the new slot.
// R15: Software treats slot id of aborted Enable Slot as invalid.
// R16: One completion event per command, in ring order.
// R17: Aborted command: post aborted event, advance dequeue, post ring-stopped event.
// R18: Software rings doorbell entry zero with command target, stream zero.
// R19: Aborted Enable Slot releases the tentatively chosen slot.
// R20: Unknown type code completes with descriptor error and no other effect.
`include "cmd_exec_defs.vh"
module cmd_exec #(
   parameter N_SLOTS = 8,
   parameter ID_W    = 4,
   parameter AW      = 64
) (
   input  wire                    clk_i,
   input  wire                    rst_n_i,
   input  wire                    doorbell_i,
   input  wire                    ring_ptr_load_i,
   input  wire [AW-1:0]           ring_ptr_i,
   input  wire                    command_abort_flag_i,
   input  wire                    desc_valid_i,
   input  wire [`DESC_TYPE_W-1:0] desc_type_i,
   input  wire                    event_producer_cycle_state_i,
   input  wire                    event_ready_i,
   input  wire [N_SLOTS:1]        slot_release_i,
   input  wire                    slot_hold_i,
   output reg                     desc_fetch_o,
   output reg  [AW-1:0]           dequeue_ptr_o,
   output reg                     command_ring_running_flag_o,
   output reg                     event_valid_o,
   output reg  [AW-1:0]           event_desc_ptr_o,
   output reg  [`CC_W-1:0]        event_code_o,
   output reg  [ID_W-1:0]         event_slot_o,
   output reg  [`DESC_TYPE_W-1:0] event_type_o,
   output reg                     event_cycle_o,
   output reg  [N_SLOTS:1]        slot_enabled_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_FETCH = 3'h1;
   localparam [2:0] ST_EXEC  = 3'h2;
   localparam [2:0] ST_POST  = 3'h3;
   localparam [2:0] ST_STOP  = 3'h4;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [2:0]             state_q;
   reg  [N_SLOTS:1]       snap_q;
   reg  [3:0]             work_q;
   reg  [`DESC_TYPE_W-1:0] type_q;
   reg                    abort_pend_q;
   reg                    stop_after_q;
   wire                   found;
   wire [ID_W-1:0]        free_id;

   // ----------------------------------------------------------------
   // Slot search
   // ----------------------------------------------------------------
   // Lowest free id keeps allocation order predictable for software   [R12]
   slot_pick #(.N_SLOTS(N_SLOTS), .ID_W(ID_W)) u_pick (
      .enabled_i (slot_enabled_o),
      .found_o   (found),
      .id_o      (free_id)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire                   abort_seen  = command_abort_flag_i && command_ring_running_flag_o;
   wire                   event_taken = event_valid_o && event_ready_i;
   wire                   is_noop     = (type_q == `TYPE_NO_OP);
   wire                   is_enable   = (type_q == `TYPE_ENABLE_SLOT);
   wire                   work_done   = (work_q == 4'h0);
   wire                   enable_go   = found && work_done && !slot_hold_i;
   // Wraps silently at the top of the address space
   wire [AW-1:0]          dequeue_d   = dequeue_ptr_o + `DESC_BYTES;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q                     <= ST_IDLE;
         snap_q                      <= {N_SLOTS{1'b0}};
         work_q                      <= 4'h0;
         type_q                      <= {`DESC_TYPE_W{1'b0}};
         abort_pend_q                <= 1'b0;
         stop_after_q                <= 1'b0;
         desc_fetch_o                <= 1'b0;
         dequeue_ptr_o               <= {AW{1'b0}};
         command_ring_running_flag_o <= 1'b0;
         event_valid_o               <= 1'b0;
         event_desc_ptr_o            <= {AW{1'b0}};
         event_code_o                <= {`CC_W{1'b0}};
         event_slot_o                <= {ID_W{1'b0}};
         event_type_o                <= {`DESC_TYPE_W{1'b0}};
         event_cycle_o               <= 1'b0;
         slot_enabled_o              <= {N_SLOTS{1'b0}};
      end else begin
         desc_fetch_o <= 1'b0;
         if (event_taken)
            event_valid_o <= 1'b0;
         // Disable path from outside; abort snapshot covers it too
         if (|slot_release_i)
            slot_enabled_o <= slot_enabled_o & ~slot_release_i;
         // Sticky until the sequence consumes it, so no abort is lost
         if (abort_seen)
            abort_pend_q <= 1'b1;
         case (state_q)
            ST_IDLE: begin
               if (ring_ptr_load_i)
                  dequeue_ptr_o <= ring_ptr_i;
               if (doorbell_i && !command_abort_flag_i) begin
                  command_ring_running_flag_o <= 1'b1;
                  desc_fetch_o                <= 1'b1;
                  state_q                     <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (abort_pend_q) begin
                  // Between commands: no aborted event, just stop   [R3]
                  state_q <= ST_STOP;
               end else if (desc_valid_i) begin
                  type_q  <= desc_type_i;
                  snap_q  <= slot_enabled_o;              // [R1]
                  work_q  <= `SLOT_WORK_CYCLES;
                  state_q <= ST_EXEC;
               end else begin
                  // Ring empty
                  command_ring_running_flag_o <= 1'b0;
                  state_q                     <= ST_IDLE;
               end
            end
            ST_EXEC: begin
               if (event_valid_o) begin
                  // Previous event not yet taken: its fields must stand   [R16]
                  // and the Enable Slot countdown pauses with them
                  state_q <= ST_EXEC;
               end else if (abort_pend_q) begin
                  // Undo partial effects, incl. a tentative slot    [R2] [R19]
                  slot_enabled_o   <= snap_q;
                  event_code_o     <= `CC_ABORTED;            // [R2]
                  event_slot_o     <= {ID_W{1'b0}};
                  stop_after_q     <= 1'b1;                  // [R17]
                  state_q          <= ST_POST;
               end else if (is_noop) begin
                  event_code_o <= `CC_SUCCESS;               // [R5] [R6]
                  event_slot_o <= {ID_W{1'b0}};
                  state_q      <= ST_POST;
               end else if (is_enable) begin
                  if (!found) begin
                     event_code_o <= `CC_NO_SLOTS;           // [R10]
                     event_slot_o <= {ID_W{1'b0}};
                     state_q      <= ST_POST;
                  end else if (enable_go) begin
                     slot_enabled_o[free_id] <= 1'b1;        // [R9] [R12]
                     event_code_o            <= `CC_SUCCESS;
                     event_slot_o            <= free_id;
                     state_q                 <= ST_POST;
                  end else if (!work_done) begin
                     work_q <= work_q - 4'h1;
                  end
               end else begin
                  event_code_o <= `CC_DESC_ERROR;            // [R20]
                  event_slot_o <= {ID_W{1'b0}};
                  state_q      <= ST_POST;
               end
               if (!event_valid_o) begin
                  event_desc_ptr_o <= dequeue_ptr_o;         // [R6] [R11]
                  event_type_o     <= `TYPE_CMD_EVENT;
                  event_cycle_o    <= event_producer_cycle_state_i; // [R11]
               end
            end
            ST_POST: begin
               // One event per command, strictly in ring order      [R16]
               if (!event_valid_o) begin
                  event_valid_o <= 1'b1;
                  dequeue_ptr_o <= dequeue_d;                  // [R17]
                  if (stop_after_q || abort_pend_q) begin
                     stop_after_q <= 1'b0;
                     state_q      <= ST_STOP;
                  end else begin
                     desc_fetch_o <= 1'b1;
                     state_q      <= ST_FETCH;
                  end
               end
            end
            ST_STOP: begin
               if (!event_valid_o) begin
                  event_valid_o               <= 1'b1;
                  event_desc_ptr_o            <= dequeue_ptr_o; // [R17]
                  event_code_o                <= `CC_RING_STOPPED;
                  event_slot_o                <= {ID_W{1'b0}};
                  event_type_o                <= `TYPE_CMD_EVENT;
                  event_cycle_o               <= event_producer_cycle_state_i;
                  abort_pend_q                <= 1'b0;
                  command_ring_running_flag_o <= 1'b0;
                  state_q                     <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

/* cmd_exec_defs.vh */
// Constants for the command ring executor: type codes, completion codes, timing
`ifndef CMD_EXEC_DEFS_VH
`define CMD_EXEC_DEFS_VH
`define DESC_TYPE_W      6
`define TYPE_ENABLE_SLOT 6'h09
`define TYPE_NO_OP       6'h17
`define TYPE_CMD_EVENT   6'h21
`define CC_W             8
`define CC_SUCCESS       8'h01
`define CC_DESC_ERROR    8'h05
`define CC_NO_SLOTS      8'h09
`define CC_ABORTED       8'h19
`define CC_RING_STOPPED  8'h18
`define DESC_BYTES       64'h0000000000000010
`define SLOT_WORK_CYCLES 4'h3
`endif

/* slot_pick.v */
// Free slot search: lowest numbered disabled slot
module slot_pick #(
   parameter N_SLOTS = 8,
   parameter ID_W    = 4
) (
   input  wire [N_SLOTS:1] enabled_i,
   output reg              found_o,
   output reg  [ID_W-1:0]  id_o
);
   integer k;
   always @* begin
      found_o = 1'b0;
      id_o    = {ID_W{1'b0}};
      for (k = N_SLOTS; k >= 1; k = k - 1) begin
         if (!enabled_i[k]) begin
            found_o = 1'b1;
            id_o    = k[ID_W-1:0];
         end
      end
   end
endmodule

/* cmd_host_model.sv */
// Host software model: hands out queued command descriptors on fetch
module cmd_host_model (
   input  wire logic       clk_i,
   input  wire logic       desc_fetch_i,
   input  wire logic       stall_i,
   output logic            desc_valid_o,
   output logic [5:0]      desc_type_o,
   output logic            event_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] mem [0:15];
   logic [4:0] wr_q = 5'h00;
   logic [4:0] rd_q = 5'h00;
   wire        have = (wr_q != rd_q);
   // Answer within the fetch cycle: the executor samples at the next edge
   assign desc_valid_o  = desc_fetch_i && have;
   assign desc_type_o   = have ? mem[rd_q[3:0]] : 6'h2a;
   assign event_ready_o = ~stall_i;
   task automatic push(input logic [5:0] t);
      mem[wr_q[3:0]] = t;
      wr_q = wr_q + 5'h01;
   endtask
   always @(posedge clk_i)
      if (desc_valid_o)
         rd_q <= rd_q + 5'h01;
endmodule

/* cmd_exec_monitor.sv */
// Checker for the command executor's completion events and slot state
`include "cmd_exec_defs.vh"
module cmd_exec_monitor (
   input logic        clk_i,
   input logic        rst_n_i,
   input logic        event_ready_i,
   input logic        event_producer_cycle_state_i,
   input logic        command_ring_running_flag_o,
   input logic        event_valid_o,
   input logic [63:0] event_desc_ptr_o,
   input logic [63:0] dequeue_ptr_o,
   input logic [7:0]  event_code_o,
   input logic [3:0]  event_slot_o,
   input logic [5:0]  event_type_o,
   input logic        event_cycle_o,
   input logic [8:1]  slot_enabled_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence abort_post;
      $rose(event_valid_o) && event_code_o == `CC_ABORTED;
   endsequence
   sequence stop_post;
      event_valid_o && event_code_o == `CC_RING_STOPPED;
   endsequence
   evt_type_a: assert property (event_valid_o |-> event_type_o == `TYPE_CMD_EVENT)
      else $error("event type wrong");
   evt_hold_a: assert property (event_valid_o && !event_ready_i |=> event_valid_o
      && $stable(event_code_o) && $stable(event_desc_ptr_o)) else $error("event dropped");
   deq_step_a: assert property ($rose(event_valid_o) && event_code_o inside
      {`CC_SUCCESS, `CC_DESC_ERROR, `CC_NO_SLOTS} |-> dequeue_ptr_o == event_desc_ptr_o + 16)
      else $error("dequeue step wrong");
   no_slot_a: assert property (event_valid_o && event_code_o == `CC_NO_SLOTS
      |-> event_slot_o == 0) else $error("no-slot id not zero");
   slot_on_a: assert property (event_valid_o && event_code_o == `CC_SUCCESS
      && event_slot_o != 0 |-> slot_enabled_o[event_slot_o]) else $error("slot not enabled");
   bad_type_a: assert property ($rose(event_valid_o) && event_code_o == `CC_DESC_ERROR
      |-> event_slot_o == 0 && $stable(slot_enabled_o)) else $error("error changed slots");
   evt_cycle_a: assert property ($rose(event_valid_o)
      |-> event_cycle_o == event_producer_cycle_state_i) else $error("cycle bit wrong");
   abort_stop_a: assert property (abort_post |-> ##[1:40] stop_post)
      else $error("no stop after abort");
   stop_ptr_a: assert property (stop_post |-> event_desc_ptr_o == dequeue_ptr_o
      ##[0:20] !command_ring_running_flag_o) else $error("stop event wrong");
endmodule
bind cmd_exec cmd_exec_monitor mon_u (.clk_i, .rst_n_i, .event_ready_i,
   .event_producer_cycle_state_i, .command_ring_running_flag_o, .event_valid_o,
   .event_desc_ptr_o, .dequeue_ptr_o, .event_code_o, .event_slot_o, .event_type_o,
   .event_cycle_o, .slot_enabled_o);

/* command_ring_slot_commands_tb.sv */
// Self-checking bench for the command executor
`include "cmd_exec_defs.vh"
module command_ring_slot_commands_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_n_i = 0, doorbell_i = 0, ring_ptr_load_i = 0, stall = 0;
   logic command_abort_flag_i = 0, event_producer_cycle_state_i = 0, slot_hold_i = 0;
   logic [63:0] ring_ptr_i = 0;
   logic [8:1]  slot_release_i = 0;
   wire desc_valid_i, event_ready_i, desc_fetch_o, command_ring_running_flag_o;
   wire event_valid_o, event_cycle_o;
   wire [5:0]  desc_type_i, event_type_o;
   wire [63:0] dequeue_ptr_o, event_desc_ptr_o;
   wire [7:0]  event_code_o;
   wire [3:0]  event_slot_o;
   wire [8:1]  slot_enabled_o;
   int err_total = 0, checks = 0;
   cmd_exec dut_u (.clk_i, .rst_n_i, .doorbell_i, .ring_ptr_load_i, .ring_ptr_i,
      .command_abort_flag_i, .desc_valid_i, .desc_type_i, .event_producer_cycle_state_i,
      .event_ready_i, .slot_release_i, .slot_hold_i, .desc_fetch_o, .dequeue_ptr_o,
      .command_ring_running_flag_o, .event_valid_o, .event_desc_ptr_o, .event_code_o,
      .event_slot_o, .event_type_o, .event_cycle_o, .slot_enabled_o);
   cmd_host_model host_u (.clk_i, .desc_fetch_i(desc_fetch_o), .stall_i(stall),
      .desc_valid_o(desc_valid_i), .desc_type_o(desc_type_i), .event_ready_o(event_ready_i));
   task automatic chk(input logic [63:0] got, exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Slot 4'hf means the slot field is not compared
   task automatic ev(input logic [7:0] code, input logic [3:0] slot, input logic [63:0] ptr);
      for (int n = 0; n < 300 && event_valid_o !== 1'b1; n++) @(posedge clk_i) #1;
      chk(event_valid_o, 1'b1);
      chk(event_code_o, code);
      chk(event_desc_ptr_o, ptr);
      if (slot != 4'hf) chk(event_slot_o, slot);
      if (stall) begin
         repeat (3) @(posedge clk_i);
         #1 stall = 0;
      end
      @(posedge clk_i) #1;
   endtask
   task automatic ring(input logic [63:0] ptr);
      for (int n = 0; n < 300 && command_ring_running_flag_o !== 1'b0; n++) @(posedge clk_i) #1;
      chk(command_ring_running_flag_o, 1'b0);
      ring_ptr_i = ptr;
      ring_ptr_load_i = 1;
      @(posedge clk_i) #1 ring_ptr_load_i = 0;
      doorbell_i = 1;
      @(posedge clk_i) #1 doorbell_i = 0;
   endtask
   task automatic t_noop;
      stall = 1;
      host_u.push(`TYPE_NO_OP);
      host_u.push(6'h3f);
      ring(64'h1000);
      ev(`CC_SUCCESS, 0, 64'h1000);
      ev(`CC_DESC_ERROR, 0, 64'h1010);
      chk(slot_enabled_o, 0);
   endtask
   task automatic t_fill;
      event_producer_cycle_state_i = 1;
      repeat (9) host_u.push(`TYPE_ENABLE_SLOT);
      ring(64'h2000);
      for (int i = 1; i <= 8; i++)
         ev(`CC_SUCCESS, 4'(i), 64'h2000 + 16 * (i - 1));
      ev(`CC_NO_SLOTS, 0, 64'h2080);
      chk(slot_enabled_o, 8'hff);
   endtask
   task automatic t_release;
      slot_release_i = 8'h04;
      @(posedge clk_i) #1 slot_release_i = 0;
      host_u.push(`TYPE_ENABLE_SLOT);
      ring(64'h3000);
      ev(`CC_SUCCESS, 3, 64'h3000);
   endtask
   task automatic t_abort;
      slot_release_i = 8'h10;
      @(posedge clk_i) #1 slot_release_i = 0;
      slot_hold_i = 1;
      host_u.push(`TYPE_ENABLE_SLOT);
      ring(64'h4000);
      repeat (10) @(posedge clk_i);
      #1 command_abort_flag_i = 1;
      ev(`CC_ABORTED, 4'hf, 64'h4000);
      ev(`CC_RING_STOPPED, 0, 64'h4010);
      chk(slot_enabled_o, 8'hef);
      slot_hold_i = 0;
      host_u.push(`TYPE_NO_OP);
      ring(64'h5000);
      repeat (6) @(posedge clk_i) #1;
      chk(command_ring_running_flag_o, 0);
      command_abort_flag_i = 0;
      ring(64'h5000);
      ev(`CC_SUCCESS, 0, 64'h5000);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #4 clk_i = ~clk_i;
   initial begin
      #400000;
      err_total++;
      summarize;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      #1 rst_n_i = 1;
      t_noop;
      t_fill;
      t_release;
      t_abort;
      summarize;
   end
endmodule
